// >>> design/dsm_parser.sv
// Dial string parser with call type resolution and blind-dial delay
`timescale 1ns/1ps
`default_nettype none

module dsm_parser
    import dsm_pkg::*;
#(
    parameter int UNIT_CYCLES = DSM_DELAY_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    // Command line characters from the terminal receiver
    input wire logic I_RX_VALID,
    input wire logic [7:0] I_RX_CHAR,
    // First character of each stored number
    input wire logic [3:0][7:0] I_STORED_FIRST,
    // Setting register access
    input wire logic I_SREG_WR,
    input wire logic [DSM_SREG_IDX_W-1:0] I_SREG_IDX,
    input wire logic [7:0] I_SREG_WDATA,
    output logic [7:0] O_SREG_RDATA,
    // Call control
    input wire logic I_HANGUP,
    output logic O_CALL_VALID,
    output dsm_call_t O_CALL,
    output logic O_OFFHOOK,
    output logic O_DIAL_GO
);

    // Fold lower-case letters onto upper case
    function automatic logic [7:0] to_upper(input logic [7:0] ch);
        if (ch >= DSM_CH_LOWER_A && ch <= DSM_CH_LOWER_Z) begin
            return ch & ~DSM_CASE_BIT;
        end
        return ch;
    endfunction

    // Parser state
    dsm_state_t state_reg;
    logic voice_first_reg;      // Voice modifier right after dial letter
    logic dial_seen_reg;        // A dial string occurred on this line
    logic store_used_reg;       // Stored number selected
    logic [1:0] store_idx_reg;  // Stored location index
    // Setting registers
    logic [7:0] sreg_reg [DSM_SREG_COUNT];
    // Off-hook and delay timing
    logic offhook_reg;
    logic waiting_reg;          // Off hook, first digit not yet sent
    logic [7:0] delay_cnt_reg;  // Delay units still to run
    logic [31:0] div_cnt_reg;   // Cycles within one delay unit
    logic unit_tick;
    logic go_pulse_reg;
    logic call_valid_reg;
    dsm_call_t call_reg;

    // Decoded incoming character
    logic [7:0] ch_up;
    logic is_space;
    logic is_eol;
    logic end_call;
    logic stored_is_voice;

    assign ch_up = to_upper(I_RX_CHAR);
    assign is_space = I_RX_VALID && (I_RX_CHAR == DSM_CH_SPACE);
    assign is_eol = I_RX_VALID && (I_RX_CHAR == DSM_CH_EOL);
    // A line with a dial string starts a call unless one is up
    assign end_call = is_eol && dial_seen_reg && !offhook_reg;
    // Stored number leading with the voice modifier, any case
    assign stored_is_voice =
        to_upper(I_STORED_FIRST[store_idx_reg]) == DSM_CH_VOICE;

    // Command line parser; spaces never move it
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_reg <= DSM_ST_CMD;
        end else if (is_eol) begin
            state_reg <= DSM_ST_CMD;
        end else if (I_RX_VALID && !is_space) begin
            case (state_reg)
                DSM_ST_CMD: begin
                    // Only the dial letter opens a dial string
                    if (ch_up == DSM_CH_DIAL) begin
                        state_reg <= DSM_ST_DFIRST;
                    end
                end
                DSM_ST_DFIRST, DSM_ST_DIAL: begin
                    if (ch_up == DSM_CH_STORE) begin
                        state_reg <= DSM_ST_SEQ;
                    end else if (I_RX_CHAR == DSM_CH_NEXT) begin
                        // Later commands on the same line go on
                        state_reg <= DSM_ST_CMD;
                    end else begin
                        state_reg <= DSM_ST_DIAL;
                    end
                end
                DSM_ST_SEQ: begin
                    if (I_RX_CHAR == DSM_CH_EQUAL) begin
                        state_reg <= DSM_ST_SIDX;
                    end else begin
                        state_reg <= DSM_ST_DIAL;
                    end
                end
                DSM_ST_SIDX: begin
                    state_reg <= DSM_ST_DIAL;
                end
                default: begin
                    state_reg <= DSM_ST_CMD;
                end
            endcase
        end
    end

    // Call type and stored selection gathered over the line
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            voice_first_reg <= 1'b0;
            dial_seen_reg <= 1'b0;
            store_used_reg <= 1'b0;
            store_idx_reg <= 2'h0;
        end else if (is_eol) begin
            // Each line starts with a clean slate
            voice_first_reg <= 1'b0;
            dial_seen_reg <= 1'b0;
            store_used_reg <= 1'b0;
            store_idx_reg <= 2'h0;
        end else if (I_RX_VALID && !is_space) begin
            if (state_reg == DSM_ST_CMD && ch_up == DSM_CH_DIAL) begin
                dial_seen_reg <= 1'b1;
            end
            // Voice only counts directly after the dial letter
            if (state_reg == DSM_ST_DFIRST) begin
                voice_first_reg <= (ch_up == DSM_CH_VOICE);
            end
            // Digits outside 0..3 are passed over
            if (state_reg == DSM_ST_SIDX && I_RX_CHAR >= DSM_CH_ZERO &&
                I_RX_CHAR <= DSM_CH_THREE) begin
                store_used_reg <= 1'b1;
                store_idx_reg <= I_RX_CHAR[1:0];
            end
        end
    end

    // Call request issued at end of line
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            call_valid_reg <= 1'b0;
            call_reg <= '0;
        end else begin
            call_valid_reg <= end_call;
            if (end_call) begin
                // Leading voice wins over anything stored
                call_reg.voice <= voice_first_reg ||
                    (store_used_reg && stored_is_voice);
                call_reg.stored <= store_used_reg;
                call_reg.store_idx <= store_idx_reg;
            end
        end
    end

    // Setting register bank; out-of-range writes dropped
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            for (int i = 0; i < DSM_SREG_COUNT; i++) begin
                sreg_reg[i] <= DSM_SREG_RST;
            end
            sreg_reg[DSM_SREG_BLIND] <= DSM_BLIND_RST;
        end else if (I_SREG_WR && I_SREG_IDX < DSM_SREG_IDX_W'(DSM_SREG_COUNT))
        begin
            sreg_reg[I_SREG_IDX] <= I_SREG_WDATA;
        end
    end

    // Registered read back, zero beyond the bank
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_SREG_RDATA <= 8'h00;
        end else if (I_SREG_IDX < DSM_SREG_IDX_W'(DSM_SREG_COUNT)) begin
            O_SREG_RDATA <= sreg_reg[I_SREG_IDX];
        end else begin
            O_SREG_RDATA <= 8'h00;
        end
    end

    // Delay unit divider, runs only while waiting to dial
    assign unit_tick = waiting_reg && (div_cnt_reg == 32'(UNIT_CYCLES - 1));
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            div_cnt_reg <= 32'h0;
        end else if (!waiting_reg || unit_tick) begin
            div_cnt_reg <= 32'h0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 32'h1;
        end
    end

    // Off hook, blind delay, then first digit strobe
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            offhook_reg <= 1'b0;
            waiting_reg <= 1'b0;
            delay_cnt_reg <= 8'h00;
            go_pulse_reg <= 1'b0;
        end else begin
            go_pulse_reg <= 1'b0;
            if (I_HANGUP) begin
                offhook_reg <= 1'b0;
                waiting_reg <= 1'b0;
            end else if (call_valid_reg) begin
                offhook_reg <= 1'b1;
                waiting_reg <= 1'b1;
                // Data calls go straight to dialling
                delay_cnt_reg <= call_reg.voice ?
                    sreg_reg[DSM_SREG_BLIND] : 8'h00;
            end else if (waiting_reg) begin
                if (delay_cnt_reg == 8'h00) begin
                    waiting_reg <= 1'b0;
                    go_pulse_reg <= 1'b1;
                end else if (unit_tick) begin
                    delay_cnt_reg <= delay_cnt_reg - 8'h01;
                end
            end
        end
    end

    assign O_CALL_VALID = call_valid_reg;
    assign O_CALL = call_reg;
    assign O_OFFHOOK = offhook_reg;
    assign O_DIAL_GO = go_pulse_reg;

    // Checks on the parser and timing
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);

    property p_dial_opens;
        state_reg == DSM_ST_CMD && I_RX_VALID && ch_up == DSM_CH_DIAL
        |=> state_reg == DSM_ST_DFIRST;
    endproperty
    a_dial_opens: assert property (p_dial_opens)
        else $error("dial letter did not open a dial string");

    property p_outside_ignored;
        state_reg == DSM_ST_CMD && I_RX_VALID && !is_eol
        && ch_up != DSM_CH_DIAL |=> $stable(voice_first_reg) &&
        state_reg == DSM_ST_CMD;
    endproperty
    a_outside_ignored: assert property (p_outside_ignored)
        else $error("modifier acted on outside a dial string");

    property p_lower_voice;
        state_reg == DSM_ST_DFIRST && I_RX_VALID &&
        I_RX_CHAR == (DSM_CH_VOICE | DSM_CASE_BIT) |=> voice_first_reg;
    endproperty
    a_lower_voice: assert property (p_lower_voice)
        else $error("lower-case voice modifier not taken");

    property p_space;
        is_space |=> $stable(state_reg);
    endproperty
    a_space: assert property (p_space)
        else $error("space changed parser state");

    property p_sreg_write;
        I_SREG_WR && I_SREG_IDX < DSM_SREG_IDX_W'(DSM_SREG_COUNT)
        ##1 !I_SREG_WR && $stable(I_SREG_IDX)
        |=> O_SREG_RDATA == $past(I_SREG_WDATA, 2);
    endproperty
    a_sreg_write: assert property (p_sreg_write)
        else $error("setting register did not keep written value");

    property p_voice_call;
        end_call && voice_first_reg |=> O_CALL_VALID && O_CALL.voice;
    endproperty
    a_voice_call: assert property (p_voice_call)
        else $error("leading voice modifier did not give voice call");

    property p_data_call;
        end_call && !voice_first_reg && !store_used_reg
        |=> O_CALL_VALID && !O_CALL.voice;
    endproperty
    a_data_call: assert property (p_data_call)
        else $error("call without voice modifier was not data");

    property p_zero_delay;
        O_CALL_VALID && !I_HANGUP &&
        (!O_CALL.voice || sreg_reg[DSM_SREG_BLIND] == 8'h00)
        |=> ##1 O_DIAL_GO;
    endproperty
    a_zero_delay: assert property (p_zero_delay)
        else $error("zero delay call did not dial at once");

    property p_go_after_delay;
        O_DIAL_GO |-> delay_cnt_reg == 8'h00 && O_OFFHOOK;
    endproperty
    a_go_after_delay: assert property (p_go_after_delay)
        else $error("first digit sent before blind delay ran out");

    property p_next_cmd;
        state_reg == DSM_ST_DIAL && I_RX_VALID && I_RX_CHAR == DSM_CH_NEXT
        |=> state_reg == DSM_ST_CMD;
    endproperty
    a_next_cmd: assert property (p_next_cmd)
        else $error("dial string did not return to command mode");

    property p_store_idx;
        state_reg == DSM_ST_SIDX && I_RX_VALID && I_RX_CHAR >= DSM_CH_ZERO
        && I_RX_CHAR <= DSM_CH_THREE
        |=> store_used_reg && store_idx_reg == $past(I_RX_CHAR[1:0]);
    endproperty
    a_store_idx: assert property (p_store_idx)
        else $error("stored location index not captured");

    c_voice: cover property (O_CALL_VALID && O_CALL.voice);
    c_stored: cover property (O_CALL_VALID && O_CALL.stored);
    c_delay: cover property (waiting_reg && unit_tick);
    c_go: cover property (O_DIAL_GO);

endmodule

`default_nettype wire

// >>> pkg/dsm_pkg.sv
// Shared constants and types for the dial string modifier parser
`default_nettype none
package dsm_pkg;
    // Character codes seen on the command line (upper-case forms)
    localparam logic [7:0] DSM_CH_DIAL = 8'h44;   // Dial command letter
    localparam logic [7:0] DSM_CH_VOICE = 8'h50;  // Voice call modifier
    localparam logic [7:0] DSM_CH_DATA = 8'h54;   // Data call modifier
    localparam logic [7:0] DSM_CH_STORE = 8'h53;  // Stored number select
    localparam logic [7:0] DSM_CH_EQUAL = 8'h3d;  // Separator before index
    localparam logic [7:0] DSM_CH_SPACE = 8'h20;  // Ignored everywhere
    localparam logic [7:0] DSM_CH_EOL = 8'h0d;    // Carriage return ends line
    localparam logic [7:0] DSM_CH_NEXT = 8'h3b;   // Ends dial string early
    localparam logic [7:0] DSM_CH_ZERO = 8'h30;   // First store index digit
    localparam logic [7:0] DSM_CH_THREE = 8'h33;  // Last store index digit
    localparam logic [7:0] DSM_CH_LOWER_A = 8'h61;
    localparam logic [7:0] DSM_CH_LOWER_Z = 8'h7a;
    localparam logic [7:0] DSM_CASE_BIT = 8'h20;  // Upper/lower difference

    // Setting register bank
    localparam int DSM_SREG_COUNT = 28;
    localparam int DSM_SREG_IDX_W = 5;
    localparam logic [4:0] DSM_SREG_BLIND = 5'h06; // Blind-dial delay index
    localparam logic [7:0] DSM_SREG_RST = 8'h00;
    localparam logic [7:0] DSM_BLIND_RST = 8'h02;  // Delay units after reset

    // Time base of the blind-dial delay
    localparam int DSM_CLK_PERIOD_NS = 8;
    localparam int DSM_DELAY_UNIT_US = 1000;       // One register step
    localparam int DSM_DELAY_UNIT_CYCLES =
        (DSM_DELAY_UNIT_US * 1000) / DSM_CLK_PERIOD_NS;

    // Parser states, Gray coded along the usual path
    typedef enum logic [2:0] {
        DSM_ST_CMD    = 3'h0,
        DSM_ST_DFIRST = 3'h1,
        DSM_ST_DIAL   = 3'h3,
        DSM_ST_SEQ    = 3'h2,
        DSM_ST_SIDX   = 3'h6
    } dsm_state_t;

    // Resolved call request
    typedef struct packed {
        logic       voice;      // 1 voice call, 0 data call
        logic       stored;     // Stored number was selected
        logic [1:0] store_idx;  // Which stored number
    } dsm_call_t;
endpackage
`default_nettype wire

// >>> dv/dsm_term_model.sv
// Terminal model that types command lines into the parser
`timescale 1ns/1ps
`default_nettype none
module dsm_term_model (
    // Clock
    input wire logic i_clk,
    // Character stream
    output logic o_valid,
    output logic [7:0] o_char
);
    // Idle until a line is typed
    initial begin
        o_valid = 1'b0;
        o_char = 8'h00;
    end

    // One character a cycle, carriage return appended
    task automatic send_line(input string s);
        int i;
        for (i = 0; i <= s.len(); i++) begin
            @(negedge i_clk);
            o_valid = 1'b1;
            o_char = (i == s.len()) ? 8'h0d : s[i];
        end
        @(negedge i_clk);
        o_valid = 1'b0;
        // Released data goes to the inverse, not a stale match
        o_char = ~o_char;
    endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking testbench of the dial string parser
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dsm_pkg::*;
    localparam int UNIT = 4; // Short delay step keeps the run brief
    logic I_MCLK = 1'b0;
    logic I_RESETN = 1'b0;
    logic I_RX_VALID;
    logic [7:0] I_RX_CHAR;
    logic [3:0][7:0] I_STORED_FIRST = {8'h50, 8'h54, 8'h54, 8'h70};
    logic I_SREG_WR = 1'b0;
    logic [4:0] I_SREG_IDX = 5'h00;
    logic [7:0] I_SREG_WDATA = 8'h00;
    logic [7:0] O_SREG_RDATA;
    logic I_HANGUP = 1'b0;
    logic O_CALL_VALID;
    dsm_call_t O_CALL;
    logic O_OFFHOOK;
    logic O_DIAL_GO;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0; // Cycle count for gap measurement
    int call_cnt = 0;
    int go_cnt = 0;
    int call_cyc, go_cyc;
    dsm_call_t call_val;

    // 125 MHz clock
    always #4 I_MCLK = ~I_MCLK;

    dsm_parser #(.UNIT_CYCLES(UNIT)) i_dsm_parser (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
        .I_RX_VALID(I_RX_VALID), .I_RX_CHAR(I_RX_CHAR),
        .I_STORED_FIRST(I_STORED_FIRST),
        .I_SREG_WR(I_SREG_WR), .I_SREG_IDX(I_SREG_IDX),
        .I_SREG_WDATA(I_SREG_WDATA), .O_SREG_RDATA(O_SREG_RDATA),
        .I_HANGUP(I_HANGUP), .O_CALL_VALID(O_CALL_VALID),
        .O_CALL(O_CALL), .O_OFFHOOK(O_OFFHOOK), .O_DIAL_GO(O_DIAL_GO));

    dsm_term_model i_dsm_term_model (
        .i_clk(I_MCLK), .o_valid(I_RX_VALID), .o_char(I_RX_CHAR));

    // Pulse monitor, a little after the edge so outputs have settled
    always @(posedge I_MCLK) begin
        #1;
        cyc++;
        if (O_CALL_VALID === 1'b1) begin
            call_cnt++;
            call_cyc = cyc;
            call_val = O_CALL;
        end
        if (O_DIAL_GO === 1'b1) begin
            go_cnt++;
            go_cyc = cyc;
        end
    end

    // Verdict and end of run
    task automatic end_sim();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %b got %b", n, e, g);
        end
    endtask

    task automatic chk_byte(input string n, input logic [7:0] e,
                            input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_call(input string n, input dsm_call_t e,
                            input dsm_call_t g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    // Gap in cycles must fall inside lo..hi
    task automatic chk_range(input string n, input int lo, input int hi,
                             input int g);
        num_checks++;
        if (g < lo || g > hi) begin
            error_cnt++;
            $display("MISMATCH %s exp %0d..%0d got %0d", n, lo, hi, g);
        end
    endtask

    task automatic sreg_wr(input logic [4:0] idx, input logic [7:0] d);
        @(negedge I_MCLK);
        I_SREG_WR = 1'b1;
        I_SREG_IDX = idx;
        I_SREG_WDATA = d;
        @(negedge I_MCLK);
        I_SREG_WR = 1'b0;
    endtask

    task automatic sreg_chk(input logic [4:0] idx, input logic [7:0] e);
        @(negedge I_MCLK);
        I_SREG_IDX = idx;
        @(negedge I_MCLK);
        chk_byte("sreg_rdata", e, O_SREG_RDATA);
    endtask

    task automatic hang_up();
        @(negedge I_MCLK);
        I_HANGUP = 1'b1;
        @(negedge I_MCLK);
        I_HANGUP = 1'b0;
        @(negedge I_MCLK);
        chk_bit("offhook_after_hangup", 1'b0, O_OFFHOOK);
    endtask

    // Type a line, judge call type and time to first digit
    task automatic run_call(input string s, input logic ok,
                            input dsm_call_t e, input int gap);
        int c0, g0, k;
        c0 = call_cnt;
        g0 = go_cnt;
        i_dsm_term_model.send_line(s);
        for (k = 0; k < 8 && call_cnt == c0; k++) @(negedge I_MCLK);
        chk_bit("call_issued", ok, call_cnt != c0);
        // A call that never came ends the run at once
        if (ok && call_cnt == c0) end_sim();
        if (ok && call_cnt != c0) begin
            chk_call("call_type", e, call_val);
            for (k = 0; k < 60 && go_cnt == g0; k++) @(negedge I_MCLK);
            chk_bit("dial_go_seen", 1'b1, go_cnt != g0);
            if (go_cnt == g0) end_sim();
            chk_bit("offhook", 1'b1, O_OFFHOOK);
            chk_range("dial_gap", gap - (gap > 2), gap + (gap > 2),
                      go_cyc - call_cyc);
            hang_up();
        end
    endtask

    // Line ending while off-hook starts nothing
    task automatic t_busy();
        // First line takes the line off hook and leaves it there
        i_dsm_term_model.send_line("ATD1");
        repeat (4) @(negedge I_MCLK);
        chk_bit("offhook_held", 1'b1, O_OFFHOOK);
        run_call("ATDP2", 1'b0, 4'h0, 0);
        hang_up();
    endtask

    // Hang-up during the blind delay cancels the first digit
    task automatic t_cancel();
        int g0;
        sreg_wr(DSM_SREG_BLIND, 8'h03);
        g0 = go_cnt;
        i_dsm_term_model.send_line("ATDP4");
        repeat (5) @(negedge I_MCLK);
        I_HANGUP = 1'b1;
        @(negedge I_MCLK);
        I_HANGUP = 1'b0;
        repeat (20) @(negedge I_MCLK);
        chk_bit("dial_go_cancelled", 1'b0, go_cnt != g0);
        chk_bit("offhook_cancelled", 1'b0, O_OFFHOOK);
    endtask

    // Bound on the whole run
    initial begin
        repeat (20000) @(posedge I_MCLK);
        error_cnt++;
        end_sim();
    end

    initial begin
        repeat (3) @(negedge I_MCLK);
        I_RESETN = 1'b1;
        sreg_chk(DSM_SREG_BLIND, 8'h02);
        sreg_chk(5'h1b, 8'h00);
        sreg_wr(5'h1b, 8'ha5);
        sreg_chk(5'h1b, 8'ha5);
        sreg_wr(5'h1c, 8'h5a);
        sreg_chk(5'h1c, 8'h00);
        run_call("ATDP9,9570000", 1'b1, 4'h8, 10);
        run_call("atdt5", 1'b1, 4'h0, 2);
        run_call("A T D p 9", 1'b1, 4'h8, 10);
        run_call("ATD5", 1'b1, 4'h0, 2);
        run_call("ATDS=0", 1'b1, 4'hc, 10);
        run_call("ATDS=1", 1'b1, 4'h5, 2);
        run_call("ATDPS=2", 1'b1, 4'he, 10);
        run_call("atds=3", 1'b1, 4'hf, 10);
        run_call("ATDS=5", 1'b1, 4'h0, 2);
        run_call("ATP", 1'b0, 4'h0, 0);
        run_call("ATD5;P", 1'b1, 4'h0, 2);
        run_call("ATE0DP7", 1'b1, 4'h8, 10);
        sreg_wr(DSM_SREG_BLIND, 8'h00);
        run_call("ATDP3", 1'b1, 4'h8, 2);
        t_busy();
        t_cancel();
        end_sim();
    end
endmodule
`default_nettype wire
